// ===== hdl/rtcc_core.sv
// real-time clock counters and interval alarm timer behind the sfr port
`timescale 1ns/10ps
module rtcc_core
	import rtcc_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic soft_reset_in,
	input wire logic ref_clk_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	output logic sfr_hit_out,
	output logic rtc_irq_pending_out
);
	typedef struct packed {
		logic [7:0] div;
		logic [7:0] hundredths;
		logic [7:0] seconds;
		logic [7:0] minutes;
		logic [7:0] hours;
		logic [7:0] config_bits;
		logic [7:0] interval_target_value;
		logic [7:0] interval_count;
		logic one_shot_done;
		logic pending;
		logic [7:0] rdata;
	} rtcc_state_t;
	rtcc_state_t st_reg;
	rtcc_state_t st_next;
	logic ref_rise;
	logic tick_128;
	logic sec_tick;
	logic min_tick;
	logic hour_tick;
	logic base_tick;
	logic hours_wrap;
	logic [7:0] hours_max;
	logic alarm_event;

	// step a counter with wrap at its maximum
	function automatic logic [7:0] wrap_inc(input logic [7:0] value, input logic [7:0] limit);
		wrap_inc = (value >= limit) ? COUNT_ZERO : 8'(value + COUNT_ONE);
	endfunction : wrap_inc

	rtcc_edge_sync rtcc_edge_sync_inst (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.async_in(ref_clk_in),
		.rise_out(ref_rise)
	);

	// carry chain from the reference divider upward
	assign tick_128 = ref_rise && (st_reg.div == REF_DIV_MAX);
	assign sec_tick = tick_128 && (st_reg.hundredths >= HUNDREDTHS_MAX);
	assign min_tick = sec_tick && (st_reg.seconds >= SIXTY_MAX);
	assign hour_tick = min_tick && (st_reg.minutes >= SIXTY_MAX);
	assign hours_max = st_reg.config_bits[CFG_TWENTYFOUR_BIT] ? HOURS24_MAX : HOURS256_MAX;
	assign hours_wrap = hour_tick && (st_reg.hours >= hours_max);

	// interval time base mux
	always_comb
	begin
		case (st_reg.config_bits[CFG_BASE_HI:CFG_BASE_LO])
			BASE_TICK: base_tick = tick_128;
			BASE_SECOND: base_tick = sec_tick;
			BASE_MINUTE: base_tick = min_tick;
			BASE_HOUR: base_tick = hour_tick;
			default: base_tick = 1'b0;
		endcase
	end

	// match on the counter value that the tick produces
	assign alarm_event = st_reg.config_bits[CFG_ENABLE_BIT] && base_tick && !st_reg.one_shot_done
		&& (8'(st_reg.interval_count + COUNT_ONE) == st_reg.interval_target_value);

	// next state: time chain, interval timer, then software writes
	always_comb
	begin
		st_next = st_reg;
		if (ref_rise)
		begin
			st_next.div = wrap_inc(st_reg.div, REF_DIV_MAX);
		end
		if (tick_128)
		begin
			st_next.hundredths = wrap_inc(st_reg.hundredths, HUNDREDTHS_MAX);
		end
		if (sec_tick)
		begin
			st_next.seconds = wrap_inc(st_reg.seconds, SIXTY_MAX);
		end
		if (min_tick)
		begin
			st_next.minutes = wrap_inc(st_reg.minutes, SIXTY_MAX);
		end
		if (hour_tick)
		begin
			st_next.hours = wrap_inc(st_reg.hours, hours_max);
		end
		// interval counter: held at zero while disabled, else moves on base ticks only
		if (!st_reg.config_bits[CFG_ENABLE_BIT])
		begin
			st_next.interval_count = COUNT_ZERO;
			st_next.one_shot_done = 1'b0;
		end
		else if (base_tick && !st_reg.one_shot_done)
		begin
			st_next.interval_count = 8'(st_reg.interval_count + COUNT_ONE);
			if (alarm_event)
			begin
				st_next.interval_count = COUNT_ZERO;
				st_next.one_shot_done = st_reg.config_bits[CFG_ONE_SHOT_BIT];
			end
		end
		// software writes; hardware sets of flags still win below
		if (sfr_wr_in)
		begin
			case (sfr_addr_in)
				ADDR_CLOCK_CONFIG:
				begin
					// flags may only be cleared by software, never set
					st_next.config_bits = {sfr_wdata_in[7] & st_reg.config_bits[CFG_MIDNIGHT_BIT],
						sfr_wdata_in[6:3], sfr_wdata_in[2] & st_reg.config_bits[CFG_ALARM_BIT],
						sfr_wdata_in[1:0]};
					if (!sfr_wdata_in[CFG_ALARM_BIT])
					begin
						st_next.pending = 1'b0;
					end
				end
				ADDR_HUNDREDTHS: st_next.hundredths = sfr_wdata_in;
				ADDR_SECONDS: st_next.seconds = sfr_wdata_in;
				ADDR_MINUTES: st_next.minutes = sfr_wdata_in;
				ADDR_HOURS: st_next.hours = sfr_wdata_in;
				ADDR_INTERVAL: st_next.interval_target_value = sfr_wdata_in;
				default: st_next.div = st_next.div;
			endcase
		end
		if (alarm_event)
		begin
			st_next.config_bits[CFG_ALARM_BIT] = 1'b1;
			st_next.pending = 1'b1;
		end
		if (hours_wrap)
		begin
			st_next.config_bits[CFG_MIDNIGHT_BIT] = 1'b1;
			st_next.pending = 1'b1;
		end
		// read data captured on the read strobe
		if (sfr_rd_in)
		begin
			case (sfr_addr_in)
				ADDR_CLOCK_CONFIG: st_next.rdata = st_reg.config_bits;
				ADDR_HUNDREDTHS: st_next.rdata = st_reg.hundredths;
				ADDR_SECONDS: st_next.rdata = st_reg.seconds;
				ADDR_MINUTES: st_next.rdata = st_reg.minutes;
				ADDR_HOURS: st_next.rdata = st_reg.hours;
				ADDR_INTERVAL: st_next.rdata = st_reg.interval_target_value;
				default: st_next.rdata = COUNT_ZERO;
			endcase
		end
	end

	// power-on reset clears everything but the keep bit; soft reset spares the time counters, midnight flag and 24-hour mode
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			st_reg <= '0;
			st_reg.config_bits <= CFG_RESET;
		end
		else if (soft_reset_in)
		begin
			st_reg.config_bits <= {st_reg.config_bits[CFG_MIDNIGHT_BIT], st_reg.config_bits[CFG_TWENTYFOUR_BIT],
				CFG_RESET[5:0]};
			st_reg.interval_target_value <= COUNT_ZERO;
			st_reg.interval_count <= COUNT_ZERO;
			st_reg.one_shot_done <= 1'b0;
			st_reg.pending <= 1'b0;
			st_reg.rdata <= COUNT_ZERO;
			st_reg.div <= st_next.div;
			st_reg.hundredths <= st_next.hundredths;
			st_reg.seconds <= st_next.seconds;
			st_reg.minutes <= st_next.minutes;
			st_reg.hours <= st_next.hours;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign sfr_rdata_out = st_reg.rdata;
	assign sfr_hit_out = (sfr_addr_in >= ADDR_CLOCK_CONFIG) && (sfr_addr_in <= ADDR_INTERVAL);
	assign rtc_irq_pending_out = st_reg.pending;

	alarm_sets_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || soft_reset_in)
		alarm_event |=> st_reg.config_bits[CFG_ALARM_BIT] && rtc_irq_pending_out)
		else $error("alarm match did not set flag and pending");
	no_sw_set_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || soft_reset_in)
		!st_reg.config_bits[CFG_ALARM_BIT] && !alarm_event |=> !st_reg.config_bits[CFG_ALARM_BIT])
		else $error("alarm flag set without a match");
	hold_zero_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || soft_reset_in)
		!st_reg.config_bits[CFG_ENABLE_BIT] |=> st_reg.interval_count == COUNT_ZERO)
		else $error("interval counter not held at zero");
	count_step_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || soft_reset_in)
		st_reg.config_bits[CFG_ENABLE_BIT] && !base_tick |=> $stable(st_reg.interval_count))
		else $error("interval counter moved without a tick");
	repeat_mode_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || soft_reset_in)
		alarm_event && !st_reg.config_bits[CFG_ONE_SHOT_BIT] |=> st_reg.interval_count == COUNT_ZERO
		&& !st_reg.one_shot_done)
		else $error("repeat mode did not restart interval");
	one_shot_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || soft_reset_in)
		st_reg.one_shot_done && st_reg.config_bits[CFG_ENABLE_BIT] |=> st_reg.one_shot_done
		&& st_reg.interval_count == COUNT_ZERO)
		else $error("one-shot timer restarted after its alarm");
	hund_wrap_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || soft_reset_in)
		sec_tick && !sfr_wr_in |=> st_reg.hundredths == COUNT_ZERO)
		else $error("hundredths did not wrap");
	sec_wrap_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || soft_reset_in)
		min_tick && !sfr_wr_in |=> st_reg.seconds == COUNT_ZERO && $past(st_reg.seconds) == SIXTY_MAX)
		else $error("seconds did not wrap at 59");
	min_wrap_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || soft_reset_in)
		hour_tick && !sfr_wr_in |=> st_reg.minutes == COUNT_ZERO)
		else $error("minutes did not wrap");
	tick_rate_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || soft_reset_in)
		ref_rise && st_reg.div != REF_DIV_MAX |=> st_reg.div == 8'($past(st_reg.div) + COUNT_ONE))
		else $error("reference divider did not step on a reference edge");

	alarm_seen_c: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) alarm_event);
	one_shot_c: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) st_reg.one_shot_done);
	minute_c: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) min_tick);
endmodule : rtcc_core

// ===== hdl/rtcc_pkg.sv
// package with register map, field positions and timing constants for the rtc counter block
package rtcc_pkg;
	// special function register addresses on the core's sfr port
	localparam logic [7:0] ADDR_CLOCK_CONFIG = 8'hA1;
	localparam logic [7:0] ADDR_HUNDREDTHS = 8'hA2;
	localparam logic [7:0] ADDR_SECONDS = 8'hA3;
	localparam logic [7:0] ADDR_MINUTES = 8'hA4;
	localparam logic [7:0] ADDR_HOURS = 8'hA5;
	localparam logic [7:0] ADDR_INTERVAL = 8'hA6;
	// clock configuration field positions
	localparam int CFG_MIDNIGHT_BIT = 7;
	localparam int CFG_TWENTYFOUR_BIT = 6;
	localparam int CFG_BASE_HI = 5;
	localparam int CFG_BASE_LO = 4;
	localparam int CFG_ONE_SHOT_BIT = 3;
	localparam int CFG_ALARM_BIT = 2;
	localparam int CFG_ENABLE_BIT = 1;
	localparam int CFG_KEEP_BIT = 0;
	localparam logic [7:0] CFG_RESET = 8'h01;
	// counter limits
	localparam logic [7:0] HUNDREDTHS_MAX = 8'h7F;
	localparam logic [7:0] SIXTY_MAX = 8'h3B;
	localparam logic [7:0] HOURS24_MAX = 8'h17;
	localparam logic [7:0] HOURS256_MAX = 8'hFF;
	localparam logic [7:0] COUNT_ZERO = 8'h00;
	localparam logic [7:0] COUNT_ONE = 8'h01;
	// time base select codes
	localparam logic [1:0] BASE_TICK = 2'h0;
	localparam logic [1:0] BASE_SECOND = 2'h1;
	localparam logic [1:0] BASE_MINUTE = 2'h2;
	localparam logic [1:0] BASE_HOUR = 2'h3;
	// tick generation from the calibrated 32.768 kHz reference
	localparam int REF_HZ = 32768;
	localparam int TICK_HZ = 128;
	localparam int REF_PER_TICK = REF_HZ / TICK_HZ;
	localparam logic [7:0] REF_DIV_MAX = 8'(REF_PER_TICK - 1);
endpackage : rtcc_pkg

// ===== hdl/rtcc_edge_sync.sv
// three flip-flop synchroniser and rising edge detector for the crystal reference
`timescale 1ns/10ps
module rtcc_edge_sync
	import rtcc_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic async_in,
	output logic rise_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} rtcc_sync_t;
	rtcc_sync_t st_reg;
	rtcc_sync_t st_next;

	// a change counts only once the second and third stages agree
	always_comb
	begin
		st_next = st_reg;
		st_next.s1 = async_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3)
		begin
			st_next.level = st_reg.s3;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign rise_out = st_next.level & ~st_reg.level;

	edge_once_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		rise_out |=> !rise_out)
		else $error("reference edge pulse lasted two cycles");
endmodule : rtcc_edge_sync

// ===== test/rtcc_core_bench.sv
// self-checking bench for the rtc counters and interval alarm timer
`timescale 1ns/10ps
module rtcc_core_bench;
	import rtcc_pkg::*;
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic soft_reset_in = 1'b0;
	logic ref_clk_in = 1'b0;
	logic sfr_wr_in = 1'b0;
	logic sfr_rd_in = 1'b0;
	logic [7:0] sfr_addr_in = 8'h00;
	logic [7:0] sfr_wdata_in = 8'h00;
	logic [7:0] sfr_rdata_out;
	logic sfr_hit_out;
	logic rtc_irq_pending_out;
	logic [7:0] rv;
	logic hv;
	int err_total = 0;
	int cmp_count = 0;
	rtcc_core rtcc_core_inst (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.soft_reset_in(soft_reset_in),
		.ref_clk_in(ref_clk_in),
		.sfr_wr_in(sfr_wr_in),
		.sfr_rd_in(sfr_rd_in),
		.sfr_addr_in(sfr_addr_in),
		.sfr_wdata_in(sfr_wdata_in),
		.sfr_rdata_out(sfr_rdata_out),
		.sfr_hit_out(sfr_hit_out),
		.rtc_irq_pending_out(rtc_irq_pending_out)
	);
	// 25 MHz system clock
	initial forever #20 sys_clk_in = ~sys_clk_in;
	// reference far faster than the crystal so a tick is 1024 cycles, not 195k
	initial forever
	begin
		repeat (2) @(posedge sys_clk_in);
		#1 ref_clk_in = ~ref_clk_in;
	end
	task test_done;
		$display("compares %0d, errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// one write strobe, held across exactly one sampling edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		#1 sfr_wr_in = 1'b1;
		sfr_addr_in = a;
		sfr_wdata_in = d;
		@(posedge sys_clk_in);
		#1 sfr_wr_in = 1'b0;
	endtask : wr
	// read data lands at the edge that takes the strobe
	task rd(input logic [7:0] a);
		@(posedge sys_clk_in);
		#1 sfr_rd_in = 1'b1;
		sfr_addr_in = a;
		#1 hv = sfr_hit_out;
		@(posedge sys_clk_in);
		#1 sfr_rd_in = 1'b0;
		rv = sfr_rdata_out;
	endtask : rd
	// poll the hundredths count; each poll is two cycles, bound covers three ticks
	task wait_hth(input logic [7:0] e);
		int n;
		for (n = 0; n < 1700; n++)
		begin
			rd(ADDR_HUNDREDTHS);
			if (rv === e)
				break;
		end
		if (n == 1700)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, rv, e);
			test_done();
		end
	endtask : wait_hth
	// sample pending off the edge so the registered flag has settled
	task wait_irq;
		int n;
		for (n = 0; n < 2300 && rtc_irq_pending_out !== 1'b1; n++)
		begin
			@(posedge sys_clk_in);
			#1;
		end
		if (n == 2300)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, rtc_irq_pending_out, 1'b1);
			test_done();
		end
	endtask : wait_irq
	task t_reset;
		rd(ADDR_CLOCK_CONFIG);
		chk(rv, CFG_RESET);
		chk({7'h00, hv}, 8'h01);
		rd(ADDR_HUNDREDTHS);
		chk(rv, 8'h00);
		rd(8'hA7);
		chk(rv, 8'h00);
		chk({7'h00, hv}, 8'h00);
		chk({7'h00, rtc_irq_pending_out}, 8'h00);
	endtask : t_reset
	task t_period;
		time t0;
		int d;
		wait_hth(8'h03);
		t0 = $time;
		wait_hth(8'h04);
		d = int'(($time - t0) / 40);
		cmp_count++;
		if (d < 1018 || d > 1030)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, d, 1024);
		end
	endtask : t_period
	task t_wrap;
		wr(ADDR_MINUTES, 8'h3B);
		wr(ADDR_SECONDS, 8'h3B);
		wr(ADDR_HUNDREDTHS, 8'h7F);
		wait_hth(8'h00);
		rd(ADDR_SECONDS);
		chk(rv, 8'h00);
		rd(ADDR_MINUTES);
		chk(rv, 8'h00);
		rd(ADDR_HOURS);
		chk(rv, 8'h01);
	endtask : t_wrap
	task t_repeat;
		wr(ADDR_INTERVAL, 8'h02);
		rd(ADDR_INTERVAL);
		chk(rv, 8'h02);
		wr(ADDR_CLOCK_CONFIG, 8'h03);
		wait_irq();
		rd(ADDR_CLOCK_CONFIG);
		chk(rv, 8'h07);
		wr(ADDR_CLOCK_CONFIG, 8'h03);
		wr(ADDR_CLOCK_CONFIG, 8'h07);
		rd(ADDR_CLOCK_CONFIG);
		chk(rv, 8'h03);
		chk({7'h00, rtc_irq_pending_out}, 8'h00);
		wait_irq();
	endtask : t_repeat
	task t_oneshot;
		wr(ADDR_INTERVAL, 8'h01);
		wr(ADDR_CLOCK_CONFIG, 8'h01);
		rd(ADDR_HUNDREDTHS);
		wait_hth((rv + 8'h02) & 8'h7F);
		chk({7'h00, rtc_irq_pending_out}, 8'h00);
		wr(ADDR_CLOCK_CONFIG, 8'h0B);
		wait_irq();
		wr(ADDR_CLOCK_CONFIG, 8'h0B);
		rd(ADDR_HUNDREDTHS);
		wait_hth((rv + 8'h03) & 8'h7F);
		chk({7'h00, rtc_irq_pending_out}, 8'h00);
	endtask : t_oneshot
	// each base fires only on the tick that rolls its own counter
	task t_bases;
		for (int b = 0; b < 4; b++)
		begin
			wr(ADDR_CLOCK_CONFIG, 8'h01);
			wr(ADDR_MINUTES, 8'h3B);
			wr(ADDR_SECONDS, 8'h3B);
			wr(ADDR_HUNDREDTHS, 8'h7E);
			wr(ADDR_CLOCK_CONFIG, {2'b00, 2'(b), 4'h3});
			wait_hth(8'h7F);
			chk({7'h00, rtc_irq_pending_out}, {7'h00, b == 0});
			wait_irq();
		end
		wr(ADDR_CLOCK_CONFIG, 8'h01);
	endtask : t_bases
	task t_resets;
		wr(ADDR_MINUTES, 8'h05);
		wr(ADDR_CLOCK_CONFIG, 8'h4B);
		@(posedge sys_clk_in);
		#1 soft_reset_in = 1'b1;
		@(posedge sys_clk_in);
		#1 soft_reset_in = 1'b0;
		rd(ADDR_MINUTES);
		chk(rv, 8'h05);
		rd(ADDR_CLOCK_CONFIG);
		chk(rv, 8'h41);
		resetn_in = 1'b0;
		repeat (2) @(posedge sys_clk_in);
		#1 resetn_in = 1'b1;
		rd(ADDR_MINUTES);
		chk(rv, 8'h00);
	endtask : t_resets
	// main sequence after 16 cycles of power-on reset
	initial
	begin
		repeat (16) @(posedge sys_clk_in);
		#1 resetn_in = 1'b1;
		t_reset();
		t_period();
		t_wrap();
		t_repeat();
		t_oneshot();
		t_bases();
		t_resets();
		test_done();
	end
endmodule : rtcc_core_bench
